/* File: include/chan_ctrl_pkg.sv */
// Package with constants and types for the per-channel control block
package chan_ctrl_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CHAN = 4;
  localparam int AMP_W = 8;
  localparam int EB_DEPTH = 8;
  localparam int EB_PTR_W = 3;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h00;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h04;
  localparam logic [4:0] OFS_IRQ_CLEAR = 5'h08;
  localparam logic [4:0] OFS_LATCH_VIEW = 5'h0c;
  localparam logic [4:0] OFS_SW_LOOP = 5'h10;
  localparam logic [4:0] OFS_LIVE_STATUS = 5'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IRQ_FAULT_SET_LSB = 0;
  localparam int IRQ_FAULT_GONE_LSB = 4;
  localparam int IRQ_SETTLED_BIT = 8;
  localparam int IRQ_W = 9;
  localparam int LIVE_FAULT_LSB = 0;
  localparam int LIVE_LOOP_LSB = 4;
  localparam int LIVE_SETTLED_BIT = 8;
  localparam int LATCH_OE_LSB = 0;
  localparam int LATCH_BIST_LSB = 8;
  localparam int LATCH_RXPWR_LSB = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] RST_DRIVER_LATCH = 4'h0;
  localparam logic [7:0] RST_SELFTEST_LATCH = 8'hff;
  localparam logic [3:0] RST_RX_POWER_LATCH = 4'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ_ENABLE = 9'h000;
  localparam logic [3:0] RST_SW_LOOP = 4'h0;
  localparam logic [EB_PTR_W-1:0] EB_NOMINAL_SEP = 3'h4;

  // ----------------------------------------
  // Amplitude trip points
  // ----------------------------------------
  localparam logic [AMP_W-1:0] AMP_TRIP_LOW = 8'h20;
  localparam logic [AMP_W-1:0] AMP_TRIP_MID = 8'h40;
  localparam logic [AMP_W-1:0] AMP_TRIP_HIGH = 8'h80;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SETTLE_CYCLES = 8;
  localparam int SETTLE_W = 4;

  typedef enum logic [1:0] {
    AMP_SEL_LOW = 2'b00,
    AMP_SEL_MID = 2'b01,
    AMP_SEL_HIGH = 2'b10
  } amp_sel_t;

  typedef enum logic [1:0] {
    DEV_RESET = 2'b00,
    DEV_SETTLE = 2'b01,
    DEV_RUN = 2'b10
  } dev_state_t;

  typedef struct packed {
    logic freq_bad;
    logic density_low;
    logic [AMP_W-1:0] amplitude;
  } detect_t;

  typedef struct packed {
    logic [3:0] driver_on;
    logic [7:0] selftest_n;
    logic [3:0] rx_power_on;
  } latches_t;

endpackage

/* File: core/bit_sync.sv */
// Two-stage synchroniser for a group of asynchronous levels
module bit_sync
  import chan_ctrl_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* File: core/elastic_mem.sv */
// Small elasticity memory with registered read data
module elastic_mem
  import chan_ctrl_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = EB_DEPTH,
  parameter int PTR_W = EB_PTR_W
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [PTR_W-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [PTR_W-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_r[rd_addr_in];
    end
  end

endmodule

/* File: core/channel_loopback_fault_reset.sv */
// Per-channel loopback, link fault, amplitude select and device reset logic
module channel_loopback_fault_reset
  import chan_ctrl_pkg::*;
#(
  parameter int NCH = NUM_CHAN
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Avalon-MM slave
  input wire logic [4:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  output logic irq_out,
  // Configuration pins
  input wire logic device_reset_n_in,
  input wire logic [1:0] amplitude_level_select_in,
  input wire logic [NCH-1:0] loopback_enable_in,
  input wire logic selftest_latch_enable_in,
  input wire logic driver_latch_enable_in,
  input wire logic rx_power_latch_enable_in,
  input wire logic [7:0] shared_enable_bus_in,
  // Serial and detector side
  input wire logic [NCH-1:0] tx_serial_in,
  input wire logic [NCH-1:0] line_serial_in,
  input wire detect_t [NCH-1:0] detect_in,
  output logic [NCH-1:0] serial_out,
  output logic [NCH-1:0] driver_on_out,
  output logic [7:0] selftest_on_out,
  output logic [NCH-1:0] rx_power_on_out,
  output logic [NCH-1:0] cdr_in_out,
  output logic [NCH-1:0] rx_data_out,
  output logic [NCH-1:0] link_fault_n_out
);

  // ----------------------------------------
  // Device reset sequencing
  // ----------------------------------------
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

  dev_state_t dev_state_r;
  dev_state_t dev_state_nxt;
  logic [SETTLE_W-1:0] settle_cnt_r;
  logic settled;
  logic dev_rst;

  assign dev_rst = !device_reset_n_in;
  assign settled = (dev_state_r == DEV_RUN);

  always_comb begin
    dev_state_nxt = dev_state_r;
    case (dev_state_r)
      DEV_RESET: begin
        dev_state_nxt = DEV_SETTLE;
      end
      DEV_SETTLE: begin
        if (settle_cnt_r == SETTLE_LAST) begin
          dev_state_nxt = DEV_RUN;
        end
      end
      DEV_RUN: begin
        dev_state_nxt = DEV_RUN;
      end
      default: begin
        dev_state_nxt = DEV_RESET;
      end
    endcase
    if (dev_rst) begin
      dev_state_nxt = DEV_RESET;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dev_state_r <= DEV_RESET;
    end else begin
      dev_state_r <= dev_state_nxt;
    end
  end

  // Settle count bounds release-to-run well under sixteen cycles
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settle_cnt_r <= '0;
    end else if (dev_rst || dev_state_r != DEV_SETTLE) begin
      settle_cnt_r <= '0;
    end else begin
      settle_cnt_r <= settle_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Enable latches on the shared bus
  // ----------------------------------------
  latches_t latch_r;
  logic [3:0] rx_half;
  logic [3:0] oe_half;

  // Receive and driver enables sit on the even bus lines
  for (genvar i = 0; i < 4; i++) begin : g_even
    assign oe_half[i] = shared_enable_bus_in[2*i];
    assign rx_half[i] = shared_enable_bus_in[2*i];
  end

  // Reset dominates an open latch so the safe state is certain
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_r.driver_on <= RST_DRIVER_LATCH;
    end else if (dev_rst) begin
      latch_r.driver_on <= RST_DRIVER_LATCH;
    end else if (driver_latch_enable_in) begin
      latch_r.driver_on <= oe_half;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_r.selftest_n <= RST_SELFTEST_LATCH;
    end else if (dev_rst) begin
      latch_r.selftest_n <= RST_SELFTEST_LATCH;
    end else if (selftest_latch_enable_in) begin
      latch_r.selftest_n <= shared_enable_bus_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_r.rx_power_on <= RST_RX_POWER_LATCH;
    end else if (dev_rst) begin
      latch_r.rx_power_on <= RST_RX_POWER_LATCH;
    end else if (rx_power_latch_enable_in) begin
      latch_r.rx_power_on <= rx_half;
    end
  end

  // ----------------------------------------
  // Loopback selection
  // ----------------------------------------
  logic [NCH-1:0] loop_sync;
  logic [NCH-1:0] sw_loop_r;
  logic [NCH-1:0] loop_act;

  bit_sync #(
    .WIDTH(NCH)
  ) u_loop_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(loopback_enable_in),
    .sync_out(loop_sync)
  );

  assign loop_act = loop_sync | sw_loop_r;

  // ----------------------------------------
  // Amplitude trip point
  // ----------------------------------------
  logic [AMP_W-1:0] amp_trip;

  always_comb begin
    case (amp_sel_t'(amplitude_level_select_in))
      AMP_SEL_LOW: amp_trip = AMP_TRIP_LOW;
      AMP_SEL_HIGH: amp_trip = AMP_TRIP_HIGH;
      default: amp_trip = AMP_TRIP_MID;
    endcase
  end

  // ----------------------------------------
  // Per-channel data path and fault
  // ----------------------------------------
  logic [EB_PTR_W-1:0] wr_ptr_r;
  logic [EB_PTR_W-1:0] rd_ptr_r;
  logic [NCH-1:0] fault;
  logic [NCH-1:0] rx_src;
  logic [NCH-1:0] eb_rd;

  // Write and read pointers shared across channels
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= EB_NOMINAL_SEP;
      rd_ptr_r <= '0;
    end else if (dev_rst) begin
      wr_ptr_r <= EB_NOMINAL_SEP;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    // Line input is not even looked at while looped
    assign rx_src[c] = loop_act[c] ? tx_serial_in[c] : line_serial_in[c];
    // Disabled receiver overrides every detector term
    assign fault[c] = !latch_r.rx_power_on[c] || detect_in[c].freq_bad ||
                      detect_in[c].density_low ||
                      (detect_in[c].amplitude < amp_trip);

    elastic_mem #(
      .WIDTH(1),
      .DEPTH(EB_DEPTH),
      .PTR_W(EB_PTR_W)
    ) u_eb (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      // Written every edge, zeros while unpowered; after reset, reads of cells 0 to 3 come before their first write
      .wr_en_in(1'b1),
      .wr_addr_in(wr_ptr_r),
      .wr_data_in(rx_src[c] & latch_r.rx_power_on[c]),
      .rd_addr_in(rd_ptr_r),
      .rd_data_out(eb_rd[c])
    );
  end

  // Outputs are registered, so fault shows one clock after its cause
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      serial_out <= '1;
      cdr_in_out <= '0;
      link_fault_n_out <= '0;
      rx_data_out <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        serial_out[c] <= loop_act[c] ? 1'b1 : tx_serial_in[c];
      end
      cdr_in_out <= rx_src;
      link_fault_n_out <= ~fault;
      // Data held at zero until the settle window closes
      rx_data_out <= settled ? eb_rd : '0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      driver_on_out <= RST_DRIVER_LATCH;
      selftest_on_out <= '0;
      rx_power_on_out <= RST_RX_POWER_LATCH;
    end else begin
      driver_on_out <= latch_r.driver_on;
      selftest_on_out <= ~latch_r.selftest_n;
      rx_power_on_out <= latch_r.rx_power_on;
    end
  end

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  logic [NCH-1:0] fault_d_r;
  logic settled_d_r;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_enable_r;
  logic [IRQ_W-1:0] irq_clear;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_d_r <= '1;
      settled_d_r <= 1'b0;
    end else begin
      fault_d_r <= fault;
      settled_d_r <= settled;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_FAULT_SET_LSB +: NCH] = fault & ~fault_d_r;
    irq_event[IRQ_FAULT_GONE_LSB +: NCH] = ~fault & fault_d_r;
    irq_event[IRQ_SETTLED_BIT] = settled & !settled_d_r;
  end

  // A new event outranks a clear in the same cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_r & irq_enable_r);
    end
  end

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  logic req;
  logic wr_take;
  logic [31:0] rd_word;
  logic [31:0] be_mask;

  assign req = (read_in || write_in) && waitrequest_out;
  assign wr_take = write_in && !waitrequest_out;

  for (genvar b = 0; b < 4; b++) begin : g_be
    assign be_mask[8*b +: 8] = {8{byteenable_in[b]}};
  end

  assign irq_clear = (wr_take && address_in == OFS_IRQ_CLEAR) ?
                     (writedata_in[IRQ_W-1:0] & be_mask[IRQ_W-1:0]) : '0;

  // Fixed one-cycle answer keeps the slave free of a state machine
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      waitrequest_out <= 1'b1;
    end else begin
      waitrequest_out <= !req;
    end
  end

  always_comb begin
    rd_word = '0;
    if (address_in == OFS_IRQ_STATUS) begin
      rd_word[IRQ_W-1:0] = irq_status_r;
    end else if (address_in == OFS_IRQ_ENABLE) begin
      rd_word[IRQ_W-1:0] = irq_enable_r;
    end else if (address_in == OFS_LATCH_VIEW) begin
      rd_word[LATCH_OE_LSB +: 4] = latch_r.driver_on;
      rd_word[LATCH_BIST_LSB +: 8] = latch_r.selftest_n;
      rd_word[LATCH_RXPWR_LSB +: 4] = latch_r.rx_power_on;
    end else if (address_in == OFS_SW_LOOP) begin
      rd_word[NCH-1:0] = sw_loop_r;
    end else if (address_in == OFS_LIVE_STATUS) begin
      rd_word[LIVE_FAULT_LSB +: NCH] = fault;
      rd_word[LIVE_LOOP_LSB +: NCH] = loop_act;
      rd_word[LIVE_SETTLED_BIT] = settled;
    end else begin
      rd_word = '0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      readdata_out <= '0;
    end else if (req && read_in) begin
      readdata_out <= rd_word;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_enable_r <= RST_IRQ_ENABLE;
    end else if (wr_take && address_in == OFS_IRQ_ENABLE) begin
      irq_enable_r <= (irq_enable_r & ~be_mask[IRQ_W-1:0]) |
                      (writedata_in[IRQ_W-1:0] & be_mask[IRQ_W-1:0]);
    end
  end

  // Software loopback is cleared by device reset like the latches and buffer pointers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_loop_r <= RST_SW_LOOP;
    end else if (dev_rst) begin
      sw_loop_r <= RST_SW_LOOP;
    end else if (wr_take && address_in == OFS_SW_LOOP && byteenable_in[0]) begin
      sw_loop_r <= writedata_in[NCH-1:0];
    end
  end

endmodule

/* File: testbench/chan_ctrl_properties.sv */
// Concurrent checks on the channel control block ports
module chan_ctrl_checker
  import chan_ctrl_pkg::*;
#(
  parameter int NCH = NUM_CHAN
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic waitrequest_out,
  input wire logic device_reset_n_in,
  input wire logic [1:0] amplitude_level_select_in,
  input wire logic [NCH-1:0] loopback_enable_in,
  input wire logic [NCH-1:0] tx_serial_in,
  input wire detect_t [NCH-1:0] detect_in,
  input wire logic [NCH-1:0] serial_out,
  input wire logic [NCH-1:0] driver_on_out,
  input wire logic [7:0] selftest_on_out,
  input wire logic [NCH-1:0] rx_power_on_out,
  input wire logic [NCH-1:0] cdr_in_out,
  input wire logic [NCH-1:0] link_fault_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------
  // Helpers
  // ---------
  logic [NCH-1:0] lp_a_r, lp_b_r, lp_c_r, held, bad;
  logic [1:0] dr_q_r;
  logic [AMP_W-1:0] trip;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Three sampled highs: exactly what two sync stages plus the output flop need
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lp_a_r <= '0;
      lp_b_r <= '0;
      lp_c_r <= '0;
      dr_q_r <= 2'h0;
    end else begin
      lp_a_r <= loopback_enable_in;
      lp_b_r <= lp_a_r;
      lp_c_r <= lp_b_r;
      dr_q_r <= {dr_q_r[0], device_reset_n_in};
    end
  end
  assign held = lp_a_r & lp_b_r & lp_c_r & {NCH{&dr_q_r}};
  assign trip = (amplitude_level_select_in == 2'h0) ? AMP_TRIP_LOW :
                (amplitude_level_select_in == 2'h2) ? AMP_TRIP_HIGH : AMP_TRIP_MID;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      bad[i] = detect_in[i].freq_bad | detect_in[i].density_low | (detect_in[i].amplitude < trip);
    end
  end
  // ---------
  // Properties
  // ---------
  property p_wait_ans;
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("bus request not answered");
  property p_wait_one;
    !waitrequest_out |=> waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
  property p_wait_idle;
    !read_in && !write_in && waitrequest_out |=> waitrequest_out;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
  property p_loop_one;
    (held & ~serial_out) == '0;
  endproperty
  a_loop_one: assert property (p_loop_one) else $error("looped output not one");
  property p_loop_cdr;
    ((cdr_in_out ^ $past(tx_serial_in)) & held) == '0;
  endproperty
  a_loop_cdr: assert property (p_loop_cdr) else $error("looped receive source");
  property p_fault_det;
    (link_fault_n_out & $past(bad)) == '0;
  endproperty
  a_fault_det: assert property (p_fault_det) else $error("fault missed");
  property p_fault_rx;
    (link_fault_n_out & ~rx_power_on_out & ~$past(rx_power_on_out)) == '0;
  endproperty
  a_fault_rx: assert property (p_fault_rx) else $error("fault missed on rx off");
  property p_latch_rst;
    !$past(device_reset_n_in, 2) |-> driver_on_out == '0 && selftest_on_out == 8'h00 &&
      rx_power_on_out == '0;
  endproperty
  a_latch_rst: assert property (p_latch_rst) else $error("latches kept");
endmodule

bind channel_loopback_fault_reset chan_ctrl_checker #(.NCH(NCH)) i_chan_ctrl_checker (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .read_in(read_in), .write_in(write_in),
  .waitrequest_out(waitrequest_out), .device_reset_n_in(device_reset_n_in),
  .amplitude_level_select_in(amplitude_level_select_in),
  .loopback_enable_in(loopback_enable_in), .tx_serial_in(tx_serial_in),
  .detect_in(detect_in), .serial_out(serial_out), .driver_on_out(driver_on_out),
  .selftest_on_out(selftest_on_out), .rx_power_on_out(rx_power_on_out),
  .cdr_in_out(cdr_in_out), .link_fault_n_out(link_fault_n_out));

/* File: testbench/host_pins.sv */
// Host model driving the reset, latch enable and shared enable pins
module host_pins (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic dr_req_in,
  input wire logic [2:0] load_sel_in,
  input wire logic [7:0] load_val_in,
  output logic device_reset_n_out,
  output logic selftest_latch_enable_out,
  output logic driver_latch_enable_out,
  output logic rx_power_latch_enable_out,
  output logic [7:0] shared_enable_bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------
  // Host pins
  // ---------
  logic [2:0] dr_cnt_r;
  logic [2:0] le_r;
  logic [7:0] bus_r;
  // Pulse after power-up so buffer pointers start known
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dr_cnt_r <= 3'h4;
    end else if (dr_req_in) begin
      dr_cnt_r <= 3'h4;
    end else if (dr_cnt_r != 3'h0) begin
      dr_cnt_r <= dr_cnt_r - 3'h1;
    end
  end
  // Idle bus shows the inverse of its last value, so a leaky latch shows up
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      le_r <= 3'h0;
      bus_r <= 8'hff;
    end else begin
      le_r <= load_sel_in;
      bus_r <= (|load_sel_in) ? load_val_in : ~bus_r;
    end
  end
  assign device_reset_n_out = (dr_cnt_r == 3'h0);
  assign {rx_power_latch_enable_out, driver_latch_enable_out, selftest_latch_enable_out} = le_r;
  assign shared_enable_bus_out = bus_r;
endmodule

/* File: testbench/channel_loopback_fault_reset_tb_top.sv */
// Self-checking bench for the channel control block
module channel_loopback_fault_reset_tb_top
  import chan_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------
  // Hookup
  // ---------
  typedef struct packed {
    logic [1:0] sel;
    detect_t det;
    logic ok;
  } row_t;
  localparam detect_t GOOD = {2'h0, 8'hff};
  localparam detect_t FREQ = {2'h2, 8'hff};
  localparam logic [12:0] ROWS [10] = '{
    {2'h0, 2'h0, 8'h1f, 1'h0}, {2'h0, 2'h0, 8'h20, 1'h1},
    {2'h1, 2'h0, 8'h3f, 1'h0}, {2'h1, 2'h0, 8'h40, 1'h1},
    {2'h2, 2'h0, 8'h7f, 1'h0}, {2'h2, 2'h0, 8'h80, 1'h1},
    {2'h3, 2'h0, 8'h3f, 1'h0}, {2'h3, 2'h0, 8'h40, 1'h1},
    {2'h2, 2'h2, 8'hff, 1'h0}, {2'h0, 2'h1, 8'hff, 1'h0}};
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [4:0] address_in = 5'h00;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic [31:0] readdata_out;
  logic waitrequest_out, irq_out, device_reset_n_in;
  logic selftest_latch_enable_in, driver_latch_enable_in, rx_power_latch_enable_in;
  logic [7:0] shared_enable_bus_in, selftest_on_out;
  logic [1:0] amplitude_level_select_in = 2'h0;
  logic [3:0] loopback_enable_in = 4'h0;
  logic [3:0] tx_serial_in = 4'h0;
  logic [3:0] line_serial_in = 4'h0;
  detect_t [3:0] detect_in = '0;
  logic [3:0] serial_out, driver_on_out, rx_power_on_out, cdr_in_out, rx_data_out;
  logic [3:0] link_fault_n_out;
  logic dr_req = 1'b0;
  logic [2:0] load_sel = 3'h0;
  logic [7:0] load_val = 8'h00;
  int n_fail = 0;
  int checks = 0;
  row_t r;
  always #10 mclk_in = ~mclk_in;
  channel_loopback_fault_reset i_channel_loopback_fault_reset (.mclk_in, .rst_n_in,
    .address_in, .read_in, .write_in, .writedata_in, .byteenable_in(4'hf), .readdata_out,
    .waitrequest_out, .irq_out, .device_reset_n_in, .amplitude_level_select_in,
    .loopback_enable_in, .selftest_latch_enable_in, .driver_latch_enable_in,
    .rx_power_latch_enable_in, .shared_enable_bus_in, .tx_serial_in, .line_serial_in,
    .detect_in, .serial_out, .driver_on_out, .selftest_on_out, .rx_power_on_out,
    .cdr_in_out, .rx_data_out, .link_fault_n_out);
  host_pins i_host_pins (.mclk_in, .rst_n_in, .dr_req_in(dr_req), .load_sel_in(load_sel),
    .load_val_in(load_val), .device_reset_n_out(device_reset_n_in),
    .selftest_latch_enable_out(selftest_latch_enable_in),
    .driver_latch_enable_out(driver_latch_enable_in),
    .rx_power_latch_enable_out(rx_power_latch_enable_in),
    .shared_enable_bus_out(shared_enable_bus_in));
  // ---------
  // Tasks
  // ---------
  task automatic wrap_up();
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Release then one idle edge, so no strobe is driven twice in a time step
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= !wr;
    do begin
      @(posedge mclk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 20);
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    if (waitrequest_out !== 1'b0) begin
      n_fail++;
      $display("CHECK FAILED %0t bus timeout", $time);
      wrap_up();
    end
    @(posedge mclk_in);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q & m, e, what);
  endtask
  task automatic load(input logic [2:0] s, input logic [7:0] v);
    load_sel <= s;
    load_val <= v;
    @(posedge mclk_in);
    load_sel <= 3'h0;
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic wait_dr();
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (device_reset_n_in !== 1'b1 && n < 20);
    if (device_reset_n_in !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t device reset timeout", $time);
      wrap_up();
    end
  endtask
  // ---------
  // Sequence
  // ---------
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    wait_dr();
    repeat (13) @(posedge mclk_in);
    rd(OFS_LIVE_STATUS, 32'h100, 32'h100, "settled");
    cmp(rx_data_out, 32'h0, "data settled");
    cmp({driver_on_out, rx_power_on_out, selftest_on_out}, 32'h0, "latch reset");
    cmp(link_fault_n_out, 32'h0, "fault rx off");
    wr(OFS_LATCH_VIEW, 32'h0);
    rd(OFS_LATCH_VIEW, 32'hffffffff, 32'h0000ff00, "latch view");
    rd(5'h1c, 32'hffffffff, 32'h0, "unmapped");
    load(3'h6, 8'h55);
    load(3'h1, 8'haa);
    rd(OFS_LATCH_VIEW, 32'hffffffff, 32'h000faa0f, "latch load");
    cmp({driver_on_out, rx_power_on_out, selftest_on_out}, 32'hff55, "latch out");
    for (int i = 0; i < 10; i++) begin
      r = ROWS[i];
      amplitude_level_select_in <= r.sel;
      detect_in <= {4{r.det}};
      repeat (2) @(posedge mclk_in);
      cmp(link_fault_n_out, {4{r.ok}}, "fault row");
    end
    detect_in <= {4{GOOD}};
    repeat (3) @(posedge mclk_in);
    wr(OFS_IRQ_ENABLE, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h1ff);
    detect_in <= {4{FREQ}};
    repeat (3) @(posedge mclk_in);
    cmp(irq_out, 32'h0, "irq masked");
    rd(OFS_IRQ_STATUS, 32'hf, 32'hf, "fault event");
    wr(OFS_IRQ_ENABLE, 32'hf);
    repeat (2) @(posedge mclk_in);
    cmp(irq_out, 32'h1, "irq on");
    detect_in <= {4{GOOD}};
    repeat (3) @(posedge mclk_in);
    wr(OFS_IRQ_CLEAR, 32'h1ff);
    repeat (2) @(posedge mclk_in);
    cmp(irq_out, 32'h0, "irq cleared");
    line_serial_in <= 4'hf;
    loopback_enable_in <= 4'h5;
    repeat (2) @(posedge mclk_in);
    cmp(serial_out, 32'h0, "sync delay");
    repeat (4) @(posedge mclk_in);
    cmp(serial_out, 32'h5, "loop one");
    cmp(cdr_in_out, 32'ha, "loop source");
    tx_serial_in <= 4'hf;
    line_serial_in <= 4'h0;
    repeat (2) @(posedge mclk_in);
    cmp(serial_out, 32'hf, "pass tx");
    cmp(cdr_in_out, 32'h5, "loop source swap");
    loopback_enable_in <= 4'h0;
    tx_serial_in <= 4'h0;
    line_serial_in <= 4'hf;
    wr(OFS_SW_LOOP, 32'ha);
    repeat (2) @(posedge mclk_in);
    cmp(serial_out, 32'ha, "sw loop one");
    cmp(cdr_in_out, 32'h5, "sw loop source");
    rd(OFS_LIVE_STATUS, 32'hf0, 32'ha0, "loop live");
    dr_req <= 1'b1;
    @(posedge mclk_in);
    dr_req <= 1'b0;
    wait_dr();
    cmp({driver_on_out, rx_power_on_out, selftest_on_out}, 32'h0, "dev reset");
    cmp(link_fault_n_out, 32'h0, "dev reset fault");
    rd(OFS_SW_LOOP, 32'hf, 32'h0, "sw loop cleared");
    load(3'h4, 8'h55);
    repeat (20) @(posedge mclk_in);
    cmp(rx_data_out, 32'hf, "elastic data");
    line_serial_in <= 4'h0;
    repeat (6) @(posedge mclk_in);
    cmp(rx_data_out, 32'hf, "elastic delay");
    @(posedge mclk_in);
    cmp(rx_data_out, 32'h0, "elastic arrive");
    wrap_up();
  end
endmodule
